// ### rtl/cba_consts.svh
`ifndef CBA_CONSTS_SVH
`define CBA_CONSTS_SVH

// register indices, byte address is four times the index
`define CBA_IDX_TEST_CTL 6'h17
`define CBA_IDX_TEST_WORD 6'h18
`define CBA_IDX_B0_LO 6'h20
`define CBA_IDX_B0_HI 6'h21
`define CBA_IDX_B1_LO 6'h22
`define CBA_IDX_B1_HI 6'h23
`define CBA_IDX_U0_LO 6'h24
`define CBA_IDX_STATUS 6'h30

// index field of the byte address
`define CBA_IDX_MSB 7
`define CBA_IDX_LSB 2

// fields
`define CBA_TEST_ON_BIT 7
`define CBA_SEL_MSB 4
`define CBA_HI_MSB 4
`define CBA_STS_ACTIVE 0
`define CBA_STS_DBL 1

// reset values
`define CBA_RST_TEST_CTL 16'h0000
`define CBA_RST_WORD 16'h0000
`define CBA_RST_HI 5'h00
`endif

// ### rtl/cba_pkg.sv
package cba_pkg;

  typedef struct packed {
    logic on;
    logic [4:0] sel;
    logic [15:0] word;
  } cba_test_t;

  typedef struct packed {
    logic active;
    logic [20:0] base;
  } cba_luma_t;

  // byte-lane merge of a 16-bit register write
  function automatic logic [15:0] cba_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                            input logic [1:0] lanes);
    logic [15:0] r;
    r = old_v;
    if (lanes[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (lanes[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction : cba_merge

endpackage : cba_pkg

// ### rtl/cba_regs.sv
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`include "cba_consts.svh"

module cba_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // capture logic side
  input wire logic double_buf_on_i,
  input wire logic frame_done_i,
  output cba_pkg::cba_test_t test_o,
  output cba_pkg::cba_luma_t luma_o
);

  logic ack_reg;
  logic [31:0] dat_reg;
  logic capture_test_on_reg;
  logic [4:0] test_sel_reg;
  logic [15:0] test_word_reg;
  logic [15:0] b0_lo_reg;
  logic [4:0] b0_hi_reg;
  logic [15:0] b1_lo_reg;
  logic [4:0] b1_hi_reg;
  logic [15:0] u0_lo_reg;
  logic buf_sel_reg;
  logic buf_sel_next;
  cba_pkg::cba_test_t test_reg;
  cba_pkg::cba_test_t test_next;
  cba_pkg::cba_luma_t luma_reg;
  cba_pkg::cba_luma_t luma_next;

  // bus decode
  // a strobe still high while ack is high is not taken a second time
  wire bus_req = cyc_i & stb_i & ~ack_reg;
  wire wr_en = bus_req & we_i;
  wire rd_en = bus_req & ~we_i;
  wire [5:0] idx = adr_i[`CBA_IDX_MSB:`CBA_IDX_LSB];
  wire [1:0] lanes = sel_i[1:0];

  wire hit_ctl = idx == `CBA_IDX_TEST_CTL;
  wire hit_word = idx == `CBA_IDX_TEST_WORD;
  wire hit_b0_lo = idx == `CBA_IDX_B0_LO;
  wire hit_b0_hi = idx == `CBA_IDX_B0_HI;
  wire hit_b1_lo = idx == `CBA_IDX_B1_LO;
  wire hit_b1_hi = idx == `CBA_IDX_B1_HI;
  wire hit_u0_lo = idx == `CBA_IDX_U0_LO;
  wire hit_sts = idx == `CBA_IDX_STATUS;

  // current register images, reserved bits zero
  wire [15:0] ctl_img = {8'h00, capture_test_on_reg, 2'h0, test_sel_reg};
  wire [15:0] b0_hi_img = {11'h000, b0_hi_reg};
  wire [15:0] b1_hi_img = {11'h000, b1_hi_reg};
  wire [15:0] sts_img = {14'h0000, double_buf_on_i, buf_sel_reg};

  // reset image of the test control register, split into its fields on reset
  wire [15:0] ctl_rst = `CBA_RST_TEST_CTL;

  // merged write values
  wire [15:0] ctl_w = cba_pkg::cba_merge(ctl_img, dat_i[15:0], lanes);
  wire [15:0] word_w = cba_pkg::cba_merge(test_word_reg, dat_i[15:0], lanes);
  wire [15:0] b0_lo_w = cba_pkg::cba_merge(b0_lo_reg, dat_i[15:0], lanes);
  wire [15:0] b0_hi_w = cba_pkg::cba_merge(b0_hi_img, dat_i[15:0], lanes);
  wire [15:0] b1_lo_w = cba_pkg::cba_merge(b1_lo_reg, dat_i[15:0], lanes);
  wire [15:0] b1_hi_w = cba_pkg::cba_merge(b1_hi_img, dat_i[15:0], lanes);
  wire [15:0] u0_lo_w = cba_pkg::cba_merge(u0_lo_reg, dat_i[15:0], lanes);

  // read mux, unmapped indices read zero
  wire [15:0] rd_mux =
    hit_ctl ? ctl_img :
    hit_word ? test_word_reg :
    hit_b0_lo ? b0_lo_reg :
    hit_b0_hi ? b0_hi_img :
    hit_b1_lo ? b1_lo_reg :
    hit_b1_hi ? b1_hi_img :
    hit_u0_lo ? u0_lo_reg :
    hit_sts ? sts_img : 16'h0000;

  // assembled start addresses
  wire [20:0] luma_buffer0_base = {b0_hi_reg, b0_lo_reg};
  wire [20:0] luma_buffer1_base = {b1_hi_reg, b1_lo_reg};

  // active buffer selection
  always_comb begin
    buf_sel_next = buf_sel_reg;
    if (!double_buf_on_i) begin
      buf_sel_next = 1'b0;
    end else if (frame_done_i) begin
      buf_sel_next = ~buf_sel_reg;
    end
  end

  always_comb begin
    luma_next.active = buf_sel_next;
    luma_next.base = buf_sel_next ? luma_buffer1_base : luma_buffer0_base;
  end

  always_comb begin
    test_next.on = capture_test_on_reg;
    test_next.sel = test_sel_reg;
    // forced to zero so stale test data never reaches the datapath in normal operation
    test_next.word = capture_test_on_reg ? test_word_reg : 16'h0000;
  end

  // bus handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req;
      if (rd_en) begin
        dat_reg <= {16'h0000, rd_mux};
      end
    end
  end

  // test control and data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_test_on_reg <= ctl_rst[`CBA_TEST_ON_BIT];
      test_sel_reg <= ctl_rst[`CBA_SEL_MSB:0];
      test_word_reg <= `CBA_RST_WORD;
    end else begin
      if (wr_en && hit_ctl) begin
        capture_test_on_reg <= ctl_w[`CBA_TEST_ON_BIT];
        test_sel_reg <= ctl_w[`CBA_SEL_MSB:0];
      end
      if (wr_en && hit_word) begin
        test_word_reg <= word_w;
      end
    end
  end

  // start address halves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      b0_lo_reg <= `CBA_RST_WORD;
      b0_hi_reg <= `CBA_RST_HI;
      b1_lo_reg <= `CBA_RST_WORD;
      b1_hi_reg <= `CBA_RST_HI;
      u0_lo_reg <= `CBA_RST_WORD;
    end else begin
      if (wr_en && hit_b0_lo) begin
        b0_lo_reg <= b0_lo_w;
      end
      if (wr_en && hit_b0_hi) begin
        b0_hi_reg <= b0_hi_w[`CBA_HI_MSB:0];
      end
      if (wr_en && hit_b1_lo) begin
        b1_lo_reg <= b1_lo_w;
      end
      if (wr_en && hit_b1_hi) begin
        b1_hi_reg <= b1_hi_w[`CBA_HI_MSB:0];
      end
      if (wr_en && hit_u0_lo) begin
        u0_lo_reg <= u0_lo_w;
      end
    end
  end

  // capture-facing outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_sel_reg <= 1'b0;
      luma_reg <= '0;
      test_reg <= '0;
    end else begin
      buf_sel_reg <= buf_sel_next;
      luma_reg <= luma_next;
      test_reg <= test_next;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign test_o = test_reg;
  assign luma_o = luma_reg;

  // high on the reset edges and the first edge after release, where $past still sees pre-reset state
  logic rst_seen_reg;

  always_ff @(posedge clk_i) begin
    rst_seen_reg <= rst_i;
  end

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || rst_seen_reg);

  ack_single_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  ack_follows_req_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged in one cycle");

  test_enable_write_a: assert property (
    wr_en && hit_ctl && sel_i[0] |=> ##1 test_o.on == $past(dat_i[`CBA_TEST_ON_BIT], 2))
    else $error("test enable bit not taken from write");

  test_select_write_a: assert property (
    wr_en && hit_ctl && sel_i[0] |=> ##1 test_o.sel == $past(dat_i[`CBA_SEL_MSB:0], 2))
    else $error("test selection not taken from write");

  test_word_gate_a: assert property (
    !test_o.on |-> test_o.word == 16'h0000)
    else $error("test word leaks out in normal operation");

  buf0_only_a: assert property (
    !$past(double_buf_on_i) |-> !luma_o.active && luma_o.base == $past(luma_buffer0_base))
    else $error("buffer 0 not used without double buffering");

  buf1_base_a: assert property (
    luma_o.active |-> $past(double_buf_on_i) && luma_o.base == $past(luma_buffer1_base))
    else $error("buffer 1 base wrong or used without double buffering");

  buf_toggle_a: assert property (
    double_buf_on_i && frame_done_i |=> luma_o.active != $past(luma_o.active))
    else $error("active buffer did not alternate");

  hi_reserved_a: assert property (
    rd_en && (hit_b0_hi || hit_b1_hi) |=> dat_o[31:`CBA_HI_MSB + 1] == 27'h0000000)
    else $error("reserved high bits read nonzero");

  buf0_assembly_a: assert property (
    wr_en && hit_b0_hi && sel_i[0] |=> luma_buffer0_base[20:16] == $past(dat_i[`CBA_HI_MSB:0]))
    else $error("buffer 0 high bits not placed at 20-16");

  write_seen_c: cover property (wr_en && hit_b1_lo ##1 ack_o);
  test_mode_c: cover property (test_o.on && test_o.word != 16'h0000);
  double_swap_c: cover property (double_buf_on_i && frame_done_i ##1 luma_o.active);
  status_read_c: cover property (rd_en && hit_sts ##1 ack_o);
  lane_write_c: cover property (wr_en && lanes == 2'b10);

  test_word_pass_a: assert property (
    test_o.on |->
    test_o.word == $past(test_word_reg))
    else $error("test word not passed on in test mode");

  test_on_track_a: assert property (
    test_o.on == $past(capture_test_on_reg))
    else $error("test enable output does not follow its register");

  test_sel_track_a: assert property (
    test_o.sel == $past(test_sel_reg))
    else $error("test selection output does not follow its register");

  ctl_readback_a: assert property (
    rd_en && hit_ctl |=>
    dat_o[`CBA_TEST_ON_BIT] == $past(capture_test_on_reg))
    else $error("test enable bit read back wrong");

  ctl_reserved_a: assert property (
    rd_en && hit_ctl |=>
    dat_o[`CBA_TEST_ON_BIT - 1:`CBA_SEL_MSB + 1] == 2'h0 && dat_o[31:`CBA_TEST_ON_BIT + 1] == 24'h000000)
    else $error("reserved control bits read nonzero");

  buf0_base_a: assert property (
    !luma_o.active |->
    luma_o.base == $past(luma_buffer0_base))
    else $error("buffer 0 active but base is not its address");

  buf1_assembly_a: assert property (
    wr_en && hit_b1_hi && sel_i[0] |=>
    luma_buffer1_base[20:16] == $past(dat_i[`CBA_HI_MSB:0]))
    else $error("buffer 1 high bits not placed at 20-16");

  buf0_low_a: assert property (
    wr_en && hit_b0_lo && (&lanes) |=>
    luma_buffer0_base[15:0] == $past(dat_i[15:0]))
    else $error("buffer 0 low half not placed at 15-0");

  buf1_low_a: assert property (
    wr_en && hit_b1_lo && (&lanes) |=>
    luma_buffer1_base[15:0] == $past(dat_i[15:0]))
    else $error("buffer 1 low half not placed at 15-0");

  buf_hold_a: assert property (
    double_buf_on_i && !frame_done_i |=>
    luma_o.active == $past(luma_o.active))
    else $error("active buffer changed without a finished picture");

  status_read_a: assert property (
    rd_en && hit_sts |=>
    dat_o[`CBA_STS_ACTIVE] == $past(luma_o.active) && dat_o[`CBA_STS_DBL] == $past(double_buf_on_i))
    else $error("status does not report the active buffer");

  rd_data_hold_a: assert property (
    !rd_en |=>
    $stable(dat_o))
    else $error("read data changed without a read");

  ack_idle_a: assert property (
    !(cyc_i && stb_i) |=>
    !ack_o)
    else $error("ack given without a request");

endmodule : cba_regs

// ### test/cba_regs_bench.sv
`timescale 1ns/1ps

module cba_regs_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic ack_o;
  logic double_buf_on_i = 1'b0;
  logic frame_done_i = 1'b0;
  cba_pkg::cba_test_t test_o;
  cba_pkg::cba_luma_t luma_o;
  logic [31:0] rd;
  int err_count = 0;
  int checks_done = 0;

  always #5 clk_i = ~clk_i;

  cba_regs uut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .double_buf_on_i(double_buf_on_i),
    .frame_done_i(frame_done_i),
    .test_o(test_o),
    .luma_o(luma_o)
  );

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_luma(input logic act, input logic [20:0] base);
    chk({10'h000, luma_o}, {10'h000, act, base});
  endtask : chk_luma

  // entered just after a rising edge; ends one idle cycle after the ack edge
  task automatic wb(input logic w, input logic [5:0] idx, input logic [15:0] d, input logic [3:0] s = 4'h3);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= s;
    dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (n >= 16) begin
      err_count++;
      test_done();
    end
    @(posedge clk_i);
  endtask : wb

  task automatic frame;
    frame_done_i <= 1'b1;
    @(posedge clk_i);
    frame_done_i <= 1'b0;
    @(posedge clk_i);
  endtask : frame

  task automatic set_dbl(input logic v);
    double_buf_on_i <= v;
    @(posedge clk_i);
    @(posedge clk_i);
  endtask : set_dbl

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({10'h000, test_o}, 32'h00000000);
    wb(1'b0, 6'h17, 16'h0000);
    chk(rd, 32'h00000000);
    wb(1'b1, 6'h17, 16'hff9f);
    wb(1'b0, 6'h17, 16'h0000);
    chk(rd, 32'h0000009f);
    chk({10'h000, test_o}, {10'h000, 1'b1, 5'h1f, 16'h0000});
    for (int i = 0; i < 32; i++) begin
      wb(1'b1, 6'h17, 16'h0080 | 16'(i));
      chk({26'h0000000, test_o.on, test_o.sel}, 32'h20 | 32'(i));
    end
    wb(1'b1, 6'h18, 16'ha5c3);
    wb(1'b0, 6'h18, 16'h0000);
    chk(rd, 32'h0000a5c3);
    chk({10'h000, test_o}, {10'h000, 1'b1, 5'h1f, 16'ha5c3});
    wb(1'b1, 6'h17, 16'h0005);
    chk({10'h000, test_o}, {10'h000, 1'b0, 5'h05, 16'h0000});
    wb(1'b1, 6'h20, 16'h1234);
    wb(1'b1, 6'h21, 16'hffff);
    wb(1'b0, 6'h21, 16'h0000);
    chk(rd, 32'h0000001f);
    chk_luma(1'b0, 21'h1f1234);
    wb(1'b1, 6'h20, 16'habcd, 4'h2);
    wb(1'b1, 6'h20, 16'h9912, 4'h1);
    wb(1'b0, 6'h20, 16'h0000);
    chk(rd, 32'h0000ab12);
    wb(1'b1, 6'h20, 16'h1234);
    wb(1'b1, 6'h22, 16'h5678);
    wb(1'b1, 6'h23, 16'h0003);
    frame();
    chk_luma(1'b0, 21'h1f1234);
    set_dbl(1'b1);
    wb(1'b0, 6'h30, 16'h0000);
    chk(rd, 32'h00000002);
    frame();
    chk_luma(1'b1, 21'h035678);
    wb(1'b0, 6'h30, 16'h0000);
    chk(rd, 32'h00000003);
    frame();
    chk_luma(1'b0, 21'h1f1234);
    frame();
    set_dbl(1'b0);
    chk_luma(1'b0, 21'h1f1234);
    wb(1'b1, 6'h3f, 16'hbeef);
    wb(1'b0, 6'h3f, 16'h0000);
    chk(rd, 32'h00000000);
    wb(1'b1, 6'h24, 16'h4321);
    wb(1'b0, 6'h24, 16'h0000);
    chk(rd, 32'h00004321);
    rst_i <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 6'h17, 16'h0000);
    chk(rd, 32'h00000000);
    test_done();
  end

  // the sequence needs well under 1000 cycles
  initial begin
    #20000;
    err_count++;
    test_done();
  end
endmodule : cba_regs_bench
